// File: logic/lcu_if.sv
// Interface joining the instruction sequencer to the compare unit.
`timescale 1ns/1ps
interface lcu_if;
	logic        instr_valid;
	logic [7:0]  fcode;
	logic [15:0] opnd_a;
	logic [15:0] opnd_b;
	logic [15:0] opnd_c;
	logic        rung_in;
	logic        res_valid;
	logic        rung_out;

	modport unit (input instr_valid, fcode, opnd_a, opnd_b, opnd_c, rung_in,
		output res_valid, rung_out);
	modport seq (output instr_valid, fcode, opnd_a, opnd_b, opnd_c, rung_in,
		input res_valid, rung_out);
endinterface : lcu_if

// File: logic/lcu_pkg.sv
// Package of function codes, widths and test/form selectors for the ladder compare unit.
package lcu_pkg;
	localparam int unsigned WORD_W   = 16;
	localparam int unsigned FCODE_W  = 8;
	localparam int unsigned TABLE_AW = 8;

	localparam logic [7:0] FC_GT_LOAD    = 8'h3e; // 62
	localparam logic [7:0] FC_GT_SER     = 8'h3f; // 63
	localparam logic [7:0] FC_GT_PAR     = 8'h40; // 64
	localparam logic [7:0] FC_GE_LOAD    = 8'h41; // 65
	localparam logic [7:0] FC_GE_SER     = 8'h42; // 66
	localparam logic [7:0] FC_GE_PAR     = 8'h43; // 67
	localparam logic [7:0] FC_MASK_LOAD  = 8'h44; // 68
	localparam logic [7:0] FC_MASK_SER   = 8'h45; // 69
	localparam logic [7:0] FC_MASK_PAR   = 8'h46; // 70
	localparam logic [7:0] FC_RANGE_LOAD = 8'h47; // 71
	localparam logic [7:0] FC_RANGE_SER  = 8'h48; // 72
	localparam logic [7:0] FC_RANGE_PAR  = 8'h49; // 73
	localparam logic [7:0] FC_FIRST    = 8'h3e;
	localparam logic [7:0] FC_LAST     = 8'h49;

	localparam logic RUNG_RESET = 1'b0;
	localparam int unsigned TABLE_WORDS = 256;

	typedef enum logic [1:0] {LCU_OP_GT, LCU_OP_GE, LCU_OP_MASK, LCU_OP_RANGE} lcu_op_type;
	typedef enum logic [1:0] {LCU_FORM_LOAD, LCU_FORM_SER, LCU_FORM_PAR, LCU_FORM_BAD} lcu_form_type;

	// Signed magnitude compare used by both limit sides and by the greater tests.
	function automatic logic lcu_sge(input logic [15:0] a, input logic [15:0] b);
		lcu_sge = ($signed(a) >= $signed(b));
	endfunction : lcu_sge
endpackage : lcu_pkg

// File: logic/lcu_seq.sv
// Sequencer end: resolves operand sources from its word table and issues instructions.
`timescale 1ns/1ps
module lcu_seq
	import lcu_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// Table write port
	input  wire logic        tbl_we_i,
	input  wire logic [7:0]  tbl_addr_i,
	input  wire logic [15:0] tbl_data_i,
	// Instruction request
	input  wire logic        req_i,
	input  wire logic [7:0]  fcode_i,
	input  wire logic [7:0]  a_addr_i,
	input  wire logic        b_is_const_i,
	input  wire logic [15:0] b_field_i,
	input  wire logic        c_is_const_i,
	input  wire logic [15:0] c_field_i,
	input  wire logic        a_is_const_i,
	input  wire logic [15:0] a_const_i,
	input  wire logic        rung_in_i,
	// Status
	output logic             req_ready_o,
	output logic             reject_o,
	output logic             done_o,
	output logic             rung_o,
	// Unit link
	lcu_if.seq               unit_if
);
	import lcu_pkg::*;

	logic [15:0] table_q [TABLE_WORDS];
	logic        issue_q;
	logic [7:0]  fcode_q;
	logic [15:0] a_q;
	logic [15:0] b_q;
	logic [15:0] c_q;
	logic        rin_q;
	logic        rej_q;

	wire is_range = (fcode_i >= FC_RANGE_LOAD) && (fcode_i <= FC_RANGE_PAR);
	wire is_gx  = (fcode_i >= FC_GT_LOAD) && (fcode_i <= FC_GE_PAR);
	// A constant operand A is only legal as the limit test value, and then both limits are table words.
	wire bad_w  = a_is_const_i && (!is_range || b_is_const_i || c_is_const_i);
	wire take_w = req_i && !bad_w;
	wire [15:0] a_val = a_is_const_i ? a_const_i : table_q[a_addr_i];
	wire [15:0] b_val = b_is_const_i ? b_field_i : table_q[b_field_i[7:0]];
	wire [15:0] c_val = c_is_const_i ? c_field_i : table_q[c_field_i[7:0]];

	always_ff @(posedge ref_clk_i)
	begin
		if (tbl_we_i)
			table_q[tbl_addr_i] <= tbl_data_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			issue_q <= 1'b0;
			fcode_q <= 8'h00;
			a_q     <= 16'h0000;
			b_q     <= 16'h0000;
			c_q     <= 16'h0000;
			rin_q   <= 1'b0;
			rej_q   <= 1'b0;
		end
		else
		begin
			issue_q <= take_w;
			rej_q   <= req_i && bad_w;
			if (take_w)
			begin
				fcode_q <= fcode_i;
				a_q     <= a_val;
				b_q     <= b_val;
				c_q     <= is_gx ? 16'h0000 : c_val;
				rin_q   <= rung_in_i;
			end
		end
	end

	assign unit_if.instr_valid = issue_q;
	assign unit_if.fcode       = fcode_q;
	assign unit_if.opnd_a      = a_q;
	assign unit_if.opnd_b      = b_q;
	assign unit_if.opnd_c      = c_q;
	assign unit_if.rung_in     = rin_q;
	assign req_ready_o         = 1'b1;
	assign reject_o            = rej_q;
	assign done_o              = unit_if.res_valid;
	assign rung_o              = unit_if.rung_out;
endmodule : lcu_seq

// File: logic/lcu_unit.sv
// Compare execution unit: decodes function codes, compares and merges into the rung.
//
// Overview of operation
// - greater-than true only when A exceeds B.
// - greater-or-equal true when A at least B.
// - compares treat words as signed 16-bit.
// - sequencer takes A from table word, or constant for limit test.
// - load starts rung; series ANDs result in.
// - parallel form ORs result into rung.
// - greater-than codes 62, 63, 64.
// - greater-or-equal codes 65, 66, 67.
// - masked-equal codes 68, 69, 70.
// - limit-test codes 71, 72, 73.
// - masked-equal true when unmasked bits match.
// - mask zero excludes bit, one includes.
// - mask may be table word or constant.
// - constant test value needs table-word limits.
// - table test value allows either limit source.
// - low at most high: inclusive inside true.
// - low above high: strictly between false.
//
// Operand use per test: A/B for the greater tests; source/mask/reference as A/B/C
// for masked-equal; test/low/high as A/B/C for the limit test.
`timescale 1ns/1ps
module lcu_unit
	import lcu_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	// Sequencer link
	lcu_if.unit       seq_if
);
	import lcu_pkg::*;

	// Link inputs under local names.
	logic         valid_w;
	logic [7:0]   fcode_w;
	logic         rung_in_w;

	// Decoded instruction fields.
	logic [7:0]   code_off;
	logic         code_ok;
	lcu_op_type   op_sel;
	lcu_form_type form_sel;
	logic         take_w;

	// Operand words as presented by the sequencer.
	logic [15:0]  a_w;
	logic [15:0]  b_w;
	logic [15:0]  c_w;

	// Comparison results, one per test, and the one the code selects.
	logic         gt_w;
	logic         ge_w;
	logic         mask_eq_w;
	logic         range_w;
	logic         cmp_w;

	// Rung and answer registers with their next values.
	logic         rung_q;
	logic         rung_d;
	logic         valid_q;
	logic         valid_d;

	// Offset of a code from the first supported one.
	function automatic logic [7:0] code_offset(
		input logic [7:0] code
	);
		code_offset = code - FC_FIRST;
	endfunction : code_offset

	// True only for codes this unit executes; anything else is left alone.
	function automatic logic code_known(
		input logic [7:0] code
	);
		code_known = (code >= FC_FIRST) && (code <= FC_LAST);
	endfunction : code_known

	// Each test owns three neighbouring codes, so the quotient picks the test.
	function automatic lcu_op_type op_of(
		input logic [7:0] off
	);
		op_of = lcu_op_type'(2'(off / 8'h03));
	endfunction : op_of

	// The remainder picks load, series or parallel within the test's three codes.
	function automatic lcu_form_type form_of(
		input logic [7:0] off
	);
		form_of = lcu_form_type'(2'(off % 8'h03));
	endfunction : form_of

	// Strict signed order, built on the shared at-least compare.
	function automatic logic strictly_above(
		input logic [15:0] a,
		input logic [15:0] b
	);
		strictly_above = !lcu_sge(b, a);
	endfunction : strictly_above

	// A cleared mask bit drops that position from the match.
	function automatic logic masked_match(
		input logic [15:0] src,
		input logic [15:0] mask,
		input logic [15:0] ref_word
	);
		masked_match = ((src ^ ref_word) & mask) == 16'h0000;
	endfunction : masked_match

	// With the limits swapped the window turns inside out, and the limits themselves stay true.
	function automatic logic range_check(
		input logic [15:0] test,
		input logic [15:0] low,
		input logic [15:0] high
	);
		logic above_low;
		logic below_high;
		above_low  = lcu_sge(test, low);
		below_high = lcu_sge(high, test);
		if (lcu_sge(high, low))
			range_check = above_low && below_high;
		else
			range_check = above_low || below_high;
	endfunction : range_check

	// Series and parallel forms fold the result into the rung handed in with the instruction.
	function automatic logic merge_rung(
		input lcu_form_type form,
		input logic         rung_prior,
		input logic         cmp,
		input logic         rung_held
	);
		unique case (form)
			LCU_FORM_LOAD: merge_rung = cmp;
			LCU_FORM_SER:  merge_rung = rung_prior & cmp;
			LCU_FORM_PAR:  merge_rung = rung_prior | cmp;
			default:       merge_rung = rung_held;
		endcase
	endfunction : merge_rung

	assign valid_w   = seq_if.instr_valid;
	assign fcode_w   = seq_if.fcode;
	assign rung_in_w = seq_if.rung_in;

	// An out-of-range code still yields some test and form; take_w keeps them harmless.
	assign code_off  = code_offset(fcode_w);
	assign code_ok   = code_known(fcode_w);
	assign op_sel    = op_of(code_off);
	assign form_sel  = form_of(code_off);
	assign take_w    = valid_w && code_ok;

	// Sources are already resolved to values, so constants and table words look alike here.
	assign a_w       = seq_if.opnd_a;
	assign b_w       = seq_if.opnd_b;
	assign c_w       = seq_if.opnd_c;

	assign gt_w      = strictly_above(a_w, b_w);
	assign ge_w      = lcu_sge(a_w, b_w);
	assign mask_eq_w = masked_match(a_w, b_w, c_w);
	assign range_w   = range_check(a_w, b_w, c_w);

	// Only the selected test reaches the rung.
	always_comb
	begin
		unique case (op_sel)
			LCU_OP_GT:    cmp_w = gt_w;
			LCU_OP_GE:    cmp_w = ge_w;
			LCU_OP_MASK:  cmp_w = mask_eq_w;
			LCU_OP_RANGE: cmp_w = range_w;
		endcase
	end

	// Unknown codes fall through with the rung held and no strobe.
	always_comb
	begin
		rung_d  = rung_q;
		valid_d = 1'b0;
		if (take_w)
		begin
			rung_d  = merge_rung(form_sel, rung_in_w, cmp_w, rung_q);
			valid_d = 1'b1;
		end
	end

	// Rung result register; reset leaves the rung false.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			rung_q <= RUNG_RESET;
		else
			rung_q <= rung_d;
	end

	// Result strobe, exactly one clock after an accepted instruction.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			valid_q <= 1'b0;
		else
			valid_q <= valid_d;
	end

	assign seq_if.rung_out  = rung_q;
	assign seq_if.res_valid = valid_q;
endmodule : lcu_unit

// File: tb/lcu_link_asserts.sv
// Checker of compare unit answers on the sequencer link.
`timescale 1ns/1ps
module lcu_link_asserts
	import lcu_pkg::*;
(
	// Link signals
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        instr_valid,
	input wire logic [7:0]  fcode,
	input wire logic [15:0] opnd_a,
	input wire logic [15:0] opnd_b,
	input wire logic [15:0] opnd_c,
	input wire logic        rung_in,
	input wire logic        res_valid,
	input wire logic        rung_out
);
	wire legal = (fcode >= FC_FIRST) && (fcode <= FC_LAST);
	wire gt    = $signed(opnd_a) > $signed(opnd_b);
	wire lo    = $signed(opnd_a) >= $signed(opnd_b);
	wire hi    = $signed(opnd_a) <= $signed(opnd_c);
	wire mask_eq  = ((opnd_a ^ opnd_c) & opnd_b) == 16'h0000;
	wire in_range = ($signed(opnd_b) <= $signed(opnd_c)) ? (lo && hi) : (lo || hi);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take(logic [7:0] f);
		instr_valid && fcode == f;
	endsequence
	chk_take_answer: assert property (instr_valid && legal |=> res_valid)
		else $error("no result after a valid code");
	chk_bad_code: assert property (instr_valid && !legal |=> !res_valid && $stable(rung_out))
		else $error("unknown code disturbed the rung");
	chk_only_answer: assert property (res_valid |-> $past(instr_valid && legal))
		else $error("result without a valid code");
	chk_rung_hold: assert property (!res_valid && $past(rst_n_i) |-> $stable(rung_out))
		else $error("rung moved without a result");
	chk_gt_load: assert property (s_take(FC_GT_LOAD) |=> rung_out == $past(gt))
		else $error("greater load wrong");
	chk_ge_series: assert property (s_take(FC_GE_SER) |=> rung_out == $past(rung_in && lo))
		else $error("greater-equal series wrong");
	chk_mask_par: assert property (s_take(FC_MASK_PAR) |=> rung_out == $past(rung_in || mask_eq))
		else $error("masked parallel wrong");
	chk_range_load: assert property (s_take(FC_RANGE_LOAD) |=> rung_out == $past(in_range))
		else $error("limit load wrong");
endmodule : lcu_link_asserts

// File: tb/tb_top.sv
// Self-checking bench: sequencer end joined to the compare unit.
`timescale 1ns/1ps
module tb_top;
	import lcu_pkg::*;
	typedef struct packed {logic [7:0] f; logic [15:0] a, b, c; logic r, e;} lcu_row_type;
	logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, tbl_we_i = 1'b0, req_i = 1'b0;
	logic        rung_in_i = 1'b0, a_is_const_i = 1'b0, b_is_const_i = 1'b1, c_is_const_i = 1'b1;
	logic [7:0]  tbl_addr_i = 8'h00, fcode_i = 8'h00, a_addr_i = 8'h00;
	logic [15:0] tbl_data_i = 16'h0000, b_field_i = 16'h0000, c_field_i = 16'h0000;
	logic [15:0] a_const_i = 16'h0000;
	logic        rej_seen;
	wire         req_ready_o, reject_o, done_o, rung_o;
	int          n_mismatch = 0, samples_checked = 0;
	lcu_row_type rows [14] = '{
		'{8'h3e, 16'h0005, 16'h0003, 16'h0000, 1'h0, 1'h1},
		'{8'h3e, 16'h0003, 16'h0003, 16'h0000, 1'h1, 1'h0},
		'{8'h3e, 16'h8000, 16'h7fff, 16'h0000, 1'h1, 1'h0},
		'{8'h3f, 16'hffff, 16'hfffe, 16'h0000, 1'h1, 1'h1},
		'{8'h40, 16'h0000, 16'h0001, 16'h0000, 1'h1, 1'h1},
		'{8'h41, 16'h0003, 16'h0003, 16'h0000, 1'h0, 1'h1},
		'{8'h42, 16'hfffe, 16'hffff, 16'h0000, 1'h1, 1'h0},
		'{8'h43, 16'h7fff, 16'h8000, 16'h0000, 1'h0, 1'h1},
		'{8'h44, 16'h12f4, 16'hff00, 16'h1234, 1'h0, 1'h1},
		'{8'h45, 16'h12f4, 16'h00f0, 16'h1234, 1'h1, 1'h0},
		'{8'h46, 16'h0000, 16'h0000, 16'hffff, 1'h0, 1'h1},
		'{8'h47, 16'h0009, 16'h0005, 16'h0008, 1'h0, 1'h0},
		'{8'h48, 16'h0006, 16'h0008, 16'h0005, 1'h1, 1'h0},
		'{8'h49, 16'h8000, 16'h0008, 16'h0005, 1'h0, 1'h1}};
	lcu_if link_if ();
	lcu_seq lcu_seq_inst (.ref_clk_i, .rst_n_i, .tbl_we_i, .tbl_addr_i, .tbl_data_i, .req_i,
		.fcode_i, .a_addr_i, .b_is_const_i, .b_field_i, .c_is_const_i, .c_field_i, .a_is_const_i,
		.a_const_i, .rung_in_i, .req_ready_o, .reject_o, .done_o, .rung_o, .unit_if(link_if));
	lcu_unit lcu_unit_inst (.ref_clk_i, .rst_n_i, .seq_if(link_if));
	lcu_link_asserts lcu_link_asserts_inst (.ref_clk_i, .rst_n_i,
		.instr_valid(link_if.instr_valid), .fcode(link_if.fcode), .opnd_a(link_if.opnd_a),
		.opnd_b(link_if.opnd_b), .opnd_c(link_if.opnd_c), .rung_in(link_if.rung_in),
		.res_valid(link_if.res_valid), .rung_out(link_if.rung_out));
	always #2 ref_clk_i = ~ref_clk_i;
	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask : chk_bit
	// Table word 0 carries operand A; the answer is sampled two edges after the request.
	task automatic issue(input lcu_row_type w, input logic ac);
		tbl_we_i = 1'b1;
		tbl_data_i = w.a;
		@(posedge ref_clk_i) #1;
		tbl_we_i = 1'b0;
		{req_i, fcode_i, a_is_const_i, a_const_i} = {1'b1, w.f, ac, w.a};
		{b_field_i, c_field_i, rung_in_i} = {w.b, w.c, w.r};
		@(posedge ref_clk_i) #1;
		req_i = 1'b0;
		rej_seen = reject_o;
		@(posedge ref_clk_i) #1;
	endtask : issue
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		#1 rst_n_i = 1'b1;
		foreach (rows[i])
		begin
			issue(rows[i], 1'b0);
			chk_bit(done_o, 1'b1, "no result");
			chk_bit(rung_o, rows[i].e, "rung value");
			$display("row %0d finished", i);
		end
		issue('{8'h3d, 16'h0000, 16'h0001, 16'h0000, 1'h0, 1'h0}, 1'b0);
		chk_bit(done_o, 1'b0, "code below range answered");
		issue('{8'h4a, 16'h0000, 16'h0001, 16'h0000, 1'h0, 1'h0}, 1'b0);
		chk_bit(rung_o, 1'b1, "unknown code moved rung");
		$display("unknown codes finished");
		{tbl_we_i, tbl_addr_i, tbl_data_i} = {1'b1, 8'h01, 16'h0005};
		@(posedge ref_clk_i) #1;
		{tbl_addr_i, b_is_const_i, c_is_const_i, b_field_i} = {8'h02, 2'b00, 16'h0001};
		issue('{8'h47, 16'h0008, 16'h0001, 16'h0002, 1'h0, 1'h0}, 1'b1);
		chk_bit(rung_o, 1'b1, "constant test value");
		issue('{8'h3e, 16'h0009, 16'h0001, 16'h0002, 1'h0, 1'h0}, 1'b1);
		chk_bit(rej_seen, 1'b1, "constant operand A accepted");
		chk_bit(done_o, 1'b0, "refused request answered");
		chk_bit(req_ready_o, 1'b1, "sequencer not ready");
		$display("operand sources finished");
		rst_n_i = 1'b0;
		@(posedge ref_clk_i) #1;
		chk_bit(rung_o, 1'b0, "reset left rung set");
		rst_n_i = 1'b1;
		$display("reset finished");
		final_report;
	end
	// Whole run is about 70 cycles; this limit is far beyond it.
	initial
	begin
		#4000;
		n_mismatch++;
		final_report;
	end
endmodule : tb_top
